// ==== include/rpsm_pkg.sv ====
// Constants and carrier types for the remappable pin select mux.
// Assumes one 10 MHz system clock and an 8-bit register port.
package rpsm_pkg;

	// Geometry
	localparam int PIN_N       = 48;
	localparam int GRP_N       = 4;
	localparam int SEL_N       = 16;
	localparam int SEL_W       = 4;
	localparam int OUT_PAIR_N  = 24;
	localparam int IN_PAIR_N   = 27;
	localparam int IN_FIELD_N  = 54;
	localparam int ADDR_W      = 6;
	localparam int DATA_W      = 8;
	localparam int NIB_HI_LSB  = 4;
	localparam int NIB_LO_LSB  = 0;

	// Register map (word index on the register port)
	localparam logic [5:0] OUT_BASE   = 6'h00;
	localparam logic [5:0] OUT_LAST   = 6'h17;
	localparam logic [5:0] IN_BASE    = 6'h20;
	localparam logic [5:0] IN_LAST    = 6'h3A;
	localparam logic [5:0] LOCK_ADDR  = 6'h3F;
	localparam int         LOCK_BIT   = 0;

	// Reset values
	localparam logic [7:0] OUT_PAIR_RST = 8'h00;
	localparam logic [7:0] IN_PAIR_RST  = 8'hFF;
	localparam logic       LOCK_RST     = 1'b0;

	// Input select encodings
	localparam logic [3:0] IN_LAST_PIN_STD = 4'hB;
	localparam logic [3:0] IN_LAST_PIN_4N3 = 4'hA;
	localparam logic [3:0] IN_SEL_GROUND   = 4'hF;

	// Output select encodings
	localparam logic [3:0] OUT_SEL_NONE      = 4'h0;
	localparam logic [3:0] OUT_SEL_SPI2_SDO  = 4'h4;
	localparam logic [3:0] OUT_SEL_RESERVED  = 4'hF;

	typedef enum logic [1:0] {
		GRP_4N,
		GRP_4N1,
		GRP_4N2,
		GRP_4N3
	} rpsm_group_type;

	// Group of every input field; field = 2 * pair index + (upper nibble)
	localparam rpsm_group_type IN_GROUP [IN_FIELD_N] = '{
		GRP_4N3, GRP_4N2, GRP_4N2, GRP_4N3, GRP_4N,  GRP_4N1,
		GRP_4N,  GRP_4N1, GRP_4N3, GRP_4N,  GRP_4N2, GRP_4N2,
		GRP_4N1, GRP_4N3, GRP_4N,  GRP_4N3, GRP_4N3, GRP_4N2,
		GRP_4N,  GRP_4N1, GRP_4N2, GRP_4N3, GRP_4N,  GRP_4N1,
		GRP_4N2, GRP_4N3, GRP_4N1, GRP_4N2, GRP_4N3, GRP_4N2,
		GRP_4N,  GRP_4N1, GRP_4N3, GRP_4N,  GRP_4N2, GRP_4N1,
		GRP_4N,  GRP_4N1, GRP_4N2, GRP_4N,  GRP_4N1, GRP_4N1,
		GRP_4N1, GRP_4N1, GRP_4N,  GRP_4N1, GRP_4N,  GRP_4N1,
		GRP_4N2, GRP_4N3, GRP_4N,  GRP_4N1, GRP_4N2, GRP_4N3
	};

	// Named input fields
	localparam int FLD_UART1_RECEIVE_IN = 0;
	localparam int FLD_SPI1_CLOCK_IN    = 8;
	localparam int FLD_SPI2_SERIAL_IN   = 12;
	localparam int FLD_SPI2_SELECT_IN   = 13;
	localparam int FLD_ENH_CAPTURE2_IN  = 16;
	localparam int FLD_EXT_IRQ1_IN      = 26;
	localparam int FLD_EXT_IRQ3_IN      = 28;
	localparam int FLD_TIMER1_GATE_IN   = 40;
	localparam int FLD_TIMER1_CLOCK_IN  = 41;

	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rpsm_bus_req_type;

	typedef struct packed {
		logic [GRP_N-1:0][SEL_N-1:0] data;
		logic [GRP_N-1:0][SEL_N-1:0] oe;
	} rpsm_periph_out_type;

endpackage : rpsm_pkg

// ==== rtl/rpsm_top.sv ====
// Remappable pin select mux: input routing, output routing, lock.
// Assumes pins come from pads (asynchronous) and peripherals share clk.
//
// Function
// - Group 4n+1 input select 0..B picks pins 1,5..45; F ties to ground.
// - Group 4n+3 input select 0..A picks pins 3,7..43; B up picks none.
// - Group 4n+1 input selects sit in fixed nibbles, e.g. timer-1 fields.
// - Group 4n+3 input selects sit in fixed nibbles, e.g. spi1 clock.
// - Each pin owns a 4-bit output field choosing its peripheral output.
// - Signals route only to pins of their own group of four.
// - Reset clears every output select field to zero.
// - Output select zero connects no peripheral to the pin.
// - Each pin offers only its group's limited set of outputs.
// - Output pair register: 8-bit RW, bits 7-4 one pin, 3-0 another.
// - Pin-select writes are ignored while the lock bit is set.
// - Reset sets input select fields to all ones, inputs grounded.
// - Each peripheral input owns a 4-bit field naming its pin.
// - Group 4n pin: 0 drives nothing, 4 drives spi2 data, F reserved.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps

module rpsm_top
	import rpsm_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   ce,
	input  wire rpsm_bus_req_type       bus_req,
	output logic [DATA_W-1:0]           rd_data,
	input  wire logic [PIN_N-1:0]       pin_in,
	output logic [PIN_N-1:0]            pin_out,
	output logic [PIN_N-1:0]            pin_oe,
	input  wire logic [PIN_N-1:0]       port_lat,
	input  wire logic [PIN_N-1:0]       port_tris,
	input  wire rpsm_periph_out_type    periph_out,
	output logic [IN_FIELD_N-1:0]       route_in,
	output logic                        route_config_lock
);

	logic [DATA_W-1:0] out_pair_r [OUT_PAIR_N];
	logic [DATA_W-1:0] in_pair_r  [IN_PAIR_N];
	logic              lock_r;
	logic [DATA_W-1:0] rd_data_r;
	logic [DATA_W-1:0] rd_data_nxt;
	logic [PIN_N-1:0]  pin_meta_r;
	logic [PIN_N-1:0]  pin_sync_r;
	logic [PIN_N-1:0]  pin_out_r;
	logic [PIN_N-1:0]  pin_oe_r;
	logic [IN_FIELD_N-1:0] route_in_r;
	logic              sel_wr_ok;
	logic [5:0]        out_idx;
	logic [5:0]        in_idx;

	assign out_idx = bus_req.addr - OUT_BASE;
	assign in_idx  = bus_req.addr - IN_BASE;

	// Map writes only go through with the lock clear
	assign sel_wr_ok = bus_req.wr && !lock_r;

	// Lock bit; itself always writable so software can reopen the map
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_r <= LOCK_RST;
		end else if (ce) begin
			if (bus_req.wr && bus_req.addr == LOCK_ADDR) begin
				lock_r <= bus_req.wdata[LOCK_BIT];
			end
		end
	end

	// Output pair registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int k = 0; k < OUT_PAIR_N; k++) begin
				out_pair_r[k] <= OUT_PAIR_RST;
			end
		end else if (ce) begin
			if (sel_wr_ok && bus_req.addr >= OUT_BASE &&
				bus_req.addr <= OUT_LAST) begin
				out_pair_r[out_idx[4:0]] <= bus_req.wdata;
			end
		end
	end

	// Input select registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int k = 0; k < IN_PAIR_N; k++) begin
				in_pair_r[k] <= IN_PAIR_RST;
			end
		end else if (ce) begin
			if (sel_wr_ok && bus_req.addr >= IN_BASE &&
				bus_req.addr <= IN_LAST) begin
				in_pair_r[in_idx[4:0]] <= bus_req.wdata;
			end
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rd_data_nxt = '0;
		if (bus_req.addr >= OUT_BASE && bus_req.addr <= OUT_LAST) begin
			rd_data_nxt = out_pair_r[out_idx[4:0]];
		end else if (bus_req.addr >= IN_BASE && bus_req.addr <= IN_LAST) begin
			rd_data_nxt = in_pair_r[in_idx[4:0]];
		end else if (bus_req.addr == LOCK_ADDR) begin
			rd_data_nxt[LOCK_BIT] = lock_r;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_r <= '0;
		end else if (ce) begin
			rd_data_r <= bus_req.rd ? rd_data_nxt : '0;
		end
	end

	// Pad synchroniser; only the second stage feeds the routing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else if (ce) begin
			pin_meta_r <= pin_in;
			pin_sync_r <= pin_meta_r;
		end
	end

	// Input routing, one field per peripheral input
	for (genvar f = 0; f < IN_FIELD_N; f++) begin : g_in
		localparam rpsm_group_type GRP = IN_GROUP[f];
		localparam int NIB_LSB = (f % 2 == 1) ? NIB_HI_LSB : NIB_LO_LSB;
		logic [SEL_W-1:0] sel;
		logic [3:0]       last;
		logic [5:0]       pin_idx;
		logic             hit;

		// Fixed nibble per input field
		assign sel = in_pair_r[f / 2][NIB_LSB +: SEL_W];
		// Group 4n+3 has one pin fewer than the other groups
		assign last = (GRP == GRP_4N3) ? IN_LAST_PIN_4N3
			: IN_LAST_PIN_STD;
		// Pin number is 4*select + group, so no select leaves the group
		assign pin_idx = {sel, GRP};
		// Unassigned codes and the ground code both read low
		assign hit = (sel <= last) && (sel != IN_SEL_GROUND);

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				route_in_r[f] <= 1'b0;
			end else if (ce) begin
				route_in_r[f] <= hit ? pin_sync_r[pin_idx] : 1'b0;
			end
		end
	end

	// Output routing, one field per pin
	for (genvar i = 0; i < PIN_N; i++) begin : g_out
		localparam int GRP     = i % GRP_N;
		localparam int NIB_LSB = (i % 2 == 1) ? NIB_HI_LSB : NIB_LO_LSB;
		logic [SEL_W-1:0] sel;
		logic             pass;

		assign sel = out_pair_r[i / 2][NIB_LSB +: SEL_W];
		// Zero and the reserved code fall back to the port; reserved is
		// treated as idle rather than left undefined on the pad
		assign pass = (sel != OUT_SEL_NONE)
			&& (sel != OUT_SEL_RESERVED);

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				pin_out_r[i] <= 1'b0;
				pin_oe_r[i]  <= 1'b0;
			end else if (ce) begin
				if (pass) begin
					// Only the pin's own group table is reachable
					pin_out_r[i] <= periph_out.data[GRP][sel];
					pin_oe_r[i]  <= periph_out.oe[GRP][sel];
				end else begin
					pin_out_r[i] <= port_lat[i];
					pin_oe_r[i]  <= !port_tris[i];
				end
			end
		end
	end

	assign rd_data           = rd_data_r;
	assign pin_out           = pin_out_r;
	assign pin_oe            = pin_oe_r;
	assign route_in          = route_in_r;
	assign route_config_lock = lock_r;

endmodule : rpsm_top

// ==== tb/rpsm_top_chk.sv ====
// Checker for rpsm_top: register port, lock and the pin 0 path.
// Assumes strobes never overlap; ce may drop, and then all state holds.
`timescale 1ns/10ps
module rpsm_top_chk
	import rpsm_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire logic                  ce,
	input wire rpsm_bus_req_type      bus_req,
	input wire logic [DATA_W-1:0]     rd_data,
	input wire logic [PIN_N-1:0]      pin_in,
	input wire logic [PIN_N-1:0]      pin_out,
	input wire logic [PIN_N-1:0]      pin_oe,
	input wire logic [PIN_N-1:0]      port_lat,
	input wire logic [PIN_N-1:0]      port_tris,
	input wire rpsm_periph_out_type   periph_out,
	input wire logic [IN_FIELD_N-1:0] route_in,
	input wire logic                  route_config_lock
);
	logic [7:0] sh_r;
	logic       up_r, lk_r, lk_wr, lat, exp_d, exp_oe;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_rd(a);
		ce && bus_req.rd && bus_req.addr == a;
	endsequence
	sequence s_lk_wr;
		ce && lk_wr;
	endsequence
	// Own shadows of pair 0 and the lock, so no expectation leans on the
	// design's outputs; up_r skips the edge where the pins still show reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			up_r <= 1'b0;
			lk_r <= LOCK_RST;
			sh_r <= OUT_PAIR_RST;
		end else if (ce) begin
			up_r <= 1'b1;
			if (lk_wr)
				lk_r <= bus_req.wdata[LOCK_BIT];
			if (bus_req.wr && bus_req.addr == OUT_BASE && !lk_r)
				sh_r <= bus_req.wdata;
		end
	end
	assign lk_wr = bus_req.wr && bus_req.addr == LOCK_ADDR;
	assign lat = sh_r[3:0] inside {OUT_SEL_NONE, OUT_SEL_RESERVED};
	assign exp_d = lat ? port_lat[0] : periph_out.data[0][sh_r[3:0]];
	assign exp_oe = lat ? !port_tris[0] : periph_out.oe[0][sh_r[3:0]];
	a_rd_idle_zero: assert property (
		ce && !bus_req.rd |=> rd_data == 8'h00) else $error("rd not idle");
	a_unmapped_rd: assert property (
		ce && bus_req.rd && bus_req.addr[5:3] == 3'h3 |=> rd_data == 8'h00)
		else $error("unmapped rd");
	a_lock_rd: assert property (
		s_rd(LOCK_ADDR) |=> rd_data == {7'h00, lk_r})
		else $error("lock rd");
	a_lock_wr: assert property (
		s_lk_wr |=> route_config_lock == $past(bus_req.wdata[LOCK_BIT]))
		else $error("lock wr");
	a_lock_keep: assert property (
		!lk_wr |=> $stable(route_config_lock)) else $error("lock moved");
	a_pair0_rd: assert property (
		s_rd(OUT_BASE) |=> rd_data == sh_r) else $error("pair 0 rd");
	a_pin0_data: assert property (
		up_r && $past(ce) |-> pin_out[0] == $past(exp_d))
		else $error("pin 0 data");
	a_pin0_oe: assert property (
		up_r && $past(ce) |-> pin_oe[0] == $past(exp_oe))
		else $error("pin 0 oe");
	a_ce_freeze: assert property (
		!ce |=> $stable(pin_out) && $stable(pin_oe) && $stable(rd_data)
			&& $stable(route_in)) else $error("state moved with ce low");
endmodule : rpsm_top_chk
bind rpsm_top rpsm_top_chk rpsm_top_chk_i (.*);

// ==== tb/rpsm_top_tb.sv ====
// Bench for rpsm_top: reset state, register port, routing and lock.
// Assumes the checker binds itself; ce is dropped once near the end.
`timescale 1ns/10ps
module rpsm_top_tb
	import rpsm_pkg::*;
;
	logic                clk = 0, rst_n = 0, ce = 1, route_config_lock;
	rpsm_bus_req_type    bus_req = '0;
	rpsm_periph_out_type periph_out;
	logic [7:0]          rd_data, d;
	logic [47:0]         pin_in, pin_out, pin_oe, port_lat, port_tris;
	logic [53:0]         route_in;
	logic [31:0]         r = 32'h4C01;
	int                  fails = 0, comparisons = 0, f, g;
	// Fields 5, 9 and 10 bring in the 4n+1, 4n and 4n+2 groups
	int                  flds[8] = '{FLD_TIMER1_CLOCK_IN, FLD_TIMER1_GATE_IN,
		5, 9, 10, FLD_SPI1_CLOCK_IN, FLD_ENH_CAPTURE2_IN, FLD_UART1_RECEIVE_IN};
	rpsm_top rpsm_top_i (.*);
	always #50 clk = ~clk;
	function automatic logic [31:0] xs();
		r ^= r << 13;
		r ^= r >> 17;
		r ^= r << 5;
		return r;
	endfunction : xs
	function automatic logic [7:0] exp_out(int i, logic [7:0] s);
		logic [3:0] v;
		v = s[4 * (i % 2) +: 4];
		if (v == OUT_SEL_NONE || v == OUT_SEL_RESERVED)
			return 8'({port_lat[i], !port_tris[i]});
		return 8'({periph_out.data[i % 4][v], periph_out.oe[i % 4][v]});
	endfunction : exp_out
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// One write, or one read checked against v; ends off the clock edge
	task automatic acc(logic w, logic [5:0] a, logic [7:0] v);
		@(posedge clk);
		bus_req <= '{a, v, w, !w};
		@(posedge clk);
		bus_req <= '0;
		@(negedge clk);
		if (!w)
			chk(rd_data, v);
	endtask : acc
	// Every register at its reset value, every pin back on its port latch
	task automatic chk_rst();
		for (int a = 0; a < 64; a++) begin
			d = 6'(a) inside {[IN_BASE:IN_LAST]} ? 8'hFF : 8'h00;
			acc(0, 6'(a), d);
		end
		chk(8'(pin_out !== port_lat), 8'h00);
		chk(8'(pin_oe !== ~port_tris), 8'h00);
		chk(8'(route_in !== '0), 8'h00);
	endtask : chk_rst
	task automatic complete_run();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	initial begin
		pin_in = 48'({xs(), xs()});
		port_lat = 48'({xs(), xs()});
		port_tris = 48'({xs(), xs()});
		periph_out = {xs(), xs(), xs(), xs()};
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		acc(1, 6'h1C, 8'hA5);
		chk_rst();
		$display("test reset done");
		for (int v = 0; v < 16; v++) begin
			f = v == 4 ? 0 : int'(xs() % 24);
			d = {r[3:0], 4'(v)};
			acc(1, 6'(f), d);
			acc(0, 6'(f), d);
			for (g = 2 * f; g < 2 * f + 2; g++)
				chk(8'({pin_out[g], pin_oe[g]}), exp_out(g, d));
		end
		$display("test outputs done");
		foreach (flds[j]) begin
			f = flds[j];
			for (int v = 0; v < 16; v++) begin
				d = f % 2 ? 8'(v * 16 + 15) : 8'(v + 240);
				@(posedge clk);
				pin_in <= 48'({xs(), xs()});
				acc(1, IN_BASE + 6'(f / 2), d);
				acc(0, IN_BASE + 6'(f / 2), d);
				g = v > (IN_GROUP[f] == GRP_4N3 ? 10 : 11) ? 48 : 4 * v + IN_GROUP[f];
				chk(8'(route_in[f]), 8'(g < 48 && pin_in[g]));
			end
		end
		$display("test inputs done");
		acc(1, OUT_BASE, 8'h73);
		acc(1, LOCK_ADDR, 8'h01);
		acc(1, OUT_BASE, 8'h5A);
		acc(1, IN_BASE, 8'h12);
		acc(0, LOCK_ADDR, 8'h01);
		acc(0, OUT_BASE, 8'h73);
		acc(0, IN_BASE, 8'hFF);
		acc(1, LOCK_ADDR, 8'h00);
		acc(1, OUT_BASE, 8'h5A);
		acc(0, OUT_BASE, 8'h5A);
		$display("test lock done");
		// Reset in mid-run, with the lock set and the map written
		acc(1, LOCK_ADDR, 8'h01);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		chk_rst();
		$display("test second reset done");
		// Clock enable low: neither a write nor a latch change gets in
		@(posedge clk);
		ce <= 1'b0;
		port_lat <= ~port_lat;
		acc(1, OUT_BASE, 8'h44);
		chk(8'(pin_out !== ~port_lat), 8'h00);
		@(posedge clk);
		ce <= 1'b1;
		acc(0, OUT_BASE, 8'h00);
		chk(8'(pin_out !== port_lat), 8'h00);
		$display("test clock enable done");
		complete_run();
	end
	// About 1000 cycles are needed; twenty times that means a hang
	initial begin
		#2000000;
		fails++;
		complete_run();
	end
endmodule : rpsm_top_tb
